// ===== icr_pkg.sv
// Package for the input capture and reload control block.
// Assumes a 32-bit classic Wishbone register bus and a 16-bit counter.
package icr_pkg;
  // Register byte addresses (printed offsets are not all multiples of four)
  localparam logic [7:0] ICR_IDX_EDGE_RELOAD = 8'ha3;
  localparam logic [7:0] ICR_IDX_FILT_FLAG = 8'ha4;
  localparam logic [7:0] ICR_IDX_MODE = 8'ha8;
  localparam logic [9:0] ICR_ADR_EDGE_RELOAD = {ICR_IDX_EDGE_RELOAD, 2'b00};
  localparam logic [9:0] ICR_ADR_FILT_FLAG = {ICR_IDX_FILT_FLAG, 2'b00};
  localparam logic [9:0] ICR_ADR_MODE = {ICR_IDX_MODE, 2'b00};
  // Field positions
  localparam int ICR_POS_EDGE2 = 6;
  localparam int ICR_POS_EDGE1 = 4;
  localparam int ICR_POS_EDGE0 = 2;
  localparam int ICR_POS_RELOAD = 0;
  localparam int ICR_POS_FILT0 = 3;
  localparam int ICR_POS_FLAG0 = 0;
  // Reset values
  localparam logic [7:0] ICR_RST_EDGE_RELOAD = 8'h00;
  localparam logic [5:0] ICR_RST_FILT = 6'h00;
  localparam logic [1:0] ICR_RST_MODE = 2'h0;
  // Edge encodings
  localparam logic [1:0] ICR_EDGE_RISE = 2'h0;
  localparam logic [1:0] ICR_EDGE_FALL = 2'h1;
  localparam logic [1:0] ICR_EDGE_BOTH = 2'h2;
  // Reload sources
  localparam logic [1:0] ICR_RLD_T3 = 2'h0;
  // Filter length in cycles
  localparam int ICR_FILT_LEN = 3;
  // Mode register bits: bit0 quadrature, bit1 compare counting
  localparam int ICR_POS_QUAD = 0;
  localparam int ICR_POS_CMPCNT = 1;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic wrap_max;
    logic direction;
  } icr_cnt_evt_t;
endpackage

// ===== icr_sync.sv
// Two-flop synchroniser for the capture pins.
// Assumes inputs asynchronous to clk_i.
`timescale 1ns/1ps
module icr_sync
  import icr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [WIDTH-1:0] d_i, // Raw pins
  output logic [WIDTH-1:0] q_o // Synchronised
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

// ===== icr_filter.sv
// Per-input glitch filter: output follows input only after it is stable.
// Assumes synchronised inputs on clk_i.
`timescale 1ns/1ps
module icr_filter
  import icr_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter int LEN = ICR_FILT_LEN
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [WIDTH-1:0] en_i, // Filter enable per input
  input wire logic [WIDTH-1:0] d_i, // Synchronised inputs
  output logic [WIDTH-1:0] q_o // Filtered or bypassed
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_ch
      logic [LEN-1:0] hist;
      logic [LEN-1:0] next_hist;
      logic held;
      logic next_held;
      always_comb begin
        next_hist = {hist[LEN-2:0], d_i[g]};
        next_held = held;
        if (&hist) begin
          next_held = 1'b1;
        end else if (~|hist) begin
          next_held = 1'b0;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hist <= '0;
          held <= 1'b0;
        end else begin
          hist <= next_hist;
          held <= next_held;
        end
      end
      assign q_o[g] = en_i[g] ? held : d_i[g];
    end
  endgenerate
endmodule

// ===== icr_top.sv
// Capture edge select, filter enables, reload source and event flags.
// Assumes classic Wishbone master on clk_i and counter events on clk_i.
`timescale 1ns/1ps
module icr_top
  import icr_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk_i, // Core clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [9:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [2:0] cap_pin_i, // Capture pins, async
  input wire logic t3_overflow_i, // Timer 3 overflow pulse
  input wire icr_cnt_evt_t cnt_evt_i, // Pulse counter events
  input wire logic [CW-1:0] count_i, // Running counter value
  output logic [3*CW-1:0] cap_value_o, // Capture registers, ch2..0
  output logic reload_o, // Counter reload pulse
  output logic [2:0] event_flag_o, // Status flags
  output logic timer2_external_trigger_o // Pin 2 for Timer 2
);
  logic [7:0] edge_reload;
  logic [2:0] filt_on;
  logic [2:0] flags;
  logic [1:0] mode;
  logic [2:0] pin_sync;
  logic [2:0] pin_filt;
  logic [2:0] pin_prev;
  logic prev_dir;
  logic [2:0] qual;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [CW-1:0] cap [3];
  logic ack;
  logic [31:0] rdat;
  logic reload;
  logic t2x;
  logic [7:0] next_edge_reload;
  logic [2:0] next_filt_on;
  logic [2:0] next_flags;
  logic [1:0] next_mode;
  logic next_ack;
  logic [31:0] next_rdat;
  logic next_reload;
  logic [2:0] next_pin_prev;
  logic next_prev_dir;
  logic [CW-1:0] next_cap [3];
  logic [2:0] hw_set;
  logic [2:0] sw_clr;
  logic acc;
  logic wr;
  logic quad;

  icr_sync #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(cap_pin_i),
    .q_o(pin_sync)
  );

  icr_filter #(.WIDTH(3), .LEN(ICR_FILT_LEN)) u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(filt_on),
    .d_i(pin_sync),
    .q_o(pin_filt)
  );

  assign acc = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign quad = mode[ICR_POS_QUAD];

  // Edge qualification per channel
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_edge
      logic [1:0] sel;
      assign sel = edge_reload[ICR_POS_EDGE0 + 2*g +: 2];
      assign rise[g] = pin_filt[g] & ~pin_prev[g];
      assign fall[g] = ~pin_filt[g] & pin_prev[g];
      always_comb begin
        case (sel)
          ICR_EDGE_RISE: qual[g] = rise[g];
          ICR_EDGE_FALL: qual[g] = fall[g];
          ICR_EDGE_BOTH: qual[g] = rise[g] | fall[g];
          default: qual[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_edge_reload = edge_reload;
    next_filt_on = filt_on;
    next_mode = mode;
    next_ack = acc;
    next_rdat = rdat;
    next_pin_prev = pin_filt;
    next_prev_dir = cnt_evt_i.direction;
    sw_clr = 3'b000;
    for (int i = 0; i < 3; i++) begin
      next_cap[i] = cap[i];
      if (qual[i]) begin
        next_cap[i] = count_i;
      end
    end
    // Hardware flag sources
    hw_set[2] = qual[2];
    if (quad) begin
      hw_set[1] = cnt_evt_i.direction != prev_dir;
      if (mode[ICR_POS_CMPCNT]) begin
        hw_set[0] = cnt_evt_i.wrap_max;
      end else begin
        hw_set[0] = cnt_evt_i.overflow | cnt_evt_i.underflow;
      end
    end else begin
      hw_set[1] = qual[1];
      hw_set[0] = qual[0];
    end
    // Reload source select
    case (edge_reload[ICR_POS_RELOAD +: 2])
      ICR_RLD_T3: next_reload = t3_overflow_i;
      2'h1: next_reload = qual[0];
      2'h2: next_reload = qual[1];
      default: next_reload = qual[2];
    endcase
    if (wr) begin
      case (wb_adr_i)
        ICR_ADR_EDGE_RELOAD: next_edge_reload = wb_dat_i[7:0];
        ICR_ADR_FILT_FLAG: begin
          next_filt_on = wb_dat_i[ICR_POS_FILT0 +: 3];
          sw_clr = ~wb_dat_i[ICR_POS_FLAG0 +: 3];
        end
        ICR_ADR_MODE: next_mode = wb_dat_i[1:0];
        default: ;
      endcase
    end
    // Set wins over clear; flags held until software clears
    next_flags = (flags & ~sw_clr) | hw_set;
    if (acc) begin
      case (wb_adr_i)
        ICR_ADR_EDGE_RELOAD: next_rdat = {24'h000000, edge_reload};
        ICR_ADR_FILT_FLAG: next_rdat = {26'h0, filt_on, flags};
        ICR_ADR_MODE: next_rdat = {30'h0, mode};
        default: next_rdat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_reload <= ICR_RST_EDGE_RELOAD;
      filt_on <= ICR_RST_FILT[5:3];
      flags <= ICR_RST_FILT[2:0];
      mode <= ICR_RST_MODE;
      ack <= 1'b0;
      rdat <= 32'h00000000;
      reload <= 1'b0;
      pin_prev <= 3'b000;
      prev_dir <= 1'b0;
      t2x <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        cap[i] <= '0;
      end
    end else begin
      edge_reload <= next_edge_reload;
      filt_on <= next_filt_on;
      flags <= next_flags;
      mode <= next_mode;
      ack <= next_ack;
      rdat <= next_rdat;
      reload <= next_reload;
      pin_prev <= next_pin_prev;
      prev_dir <= next_prev_dir;
      t2x <= pin_sync[2];
      for (int i = 0; i < 3; i++) begin
        cap[i] <= next_cap[i];
      end
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign reload_o = reload;
  assign event_flag_o = flags;
  assign timer2_external_trigger_o = t2x;
  assign cap_value_o = {cap[2], cap[1], cap[0]};

  property p_edge_flag;
    @(posedge clk_i) disable iff (rst_i)
      (qual[2]) |=> flags[2];
  endproperty
  a_edge_flag: assert property (p_edge_flag)
    else $error("chan2 flag not set after edge");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      qual[0] |=> cap[0] == $past(count_i);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value not latched");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      (hw_set[1] && sw_clr[1]) |=> flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat hardware set");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (flags[1] && !sw_clr[1]) |=> flags[1];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without clear");

  property p_dir;
    @(posedge clk_i) disable iff (rst_i)
      (quad && cnt_evt_i.direction != prev_dir) |=> flags[1];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction change not flagged");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      (edge_reload[7:6] == 2'h3) |-> !qual[2];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved edge code fired");

  property p_reload_t3;
    @(posedge clk_i) disable iff (rst_i)
      (edge_reload[1:0] == ICR_RLD_T3 && t3_overflow_i) |=> reload;
  endproperty
  a_reload_t3: assert property (p_reload_t3)
    else $error("timer 3 reload missing");

  sequence s_ack_once;
    ack ##1 !ack;
  endsequence

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !ack) |=> s_ack_once;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single cycle");

  property p_chan0_flag;
    @(posedge clk_i) disable iff (rst_i)
      (!quad && qual[0]) |=> flags[0];
  endproperty
  a_chan0_flag: assert property (p_chan0_flag)
    else $error("chan0 flag not set after edge");

  property p_chan1_flag;
    @(posedge clk_i) disable iff (rst_i)
      (!quad && qual[1]) |=> flags[1];
  endproperty
  a_chan1_flag: assert property (p_chan1_flag)
    else $error("chan1 flag not set after edge");

  property p_count_flag;
    @(posedge clk_i) disable iff (rst_i)
      (quad && !mode[ICR_POS_CMPCNT] &&
        (cnt_evt_i.overflow || cnt_evt_i.underflow)) |=> flags[0];
  endproperty
  a_count_flag: assert property (p_count_flag)
    else $error("counter overflow not flagged");

  property p_wrap_flag;
    @(posedge clk_i) disable iff (rst_i)
      (quad && mode[ICR_POS_CMPCNT] && cnt_evt_i.wrap_max) |=> flags[0];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("counter wrap not flagged");

  property p_reload_cap;
    @(posedge clk_i) disable iff (rst_i)
      (edge_reload[1:0] == 2'h1 && qual[0]) |=> reload;
  endproperty
  a_reload_cap: assert property (p_reload_cap)
    else $error("capture 0 reload missing");

  property p_t2_follow;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (t2x == $past(pin_sync[2]));
  endproperty
  a_t2_follow: assert property (p_t2_follow)
    else $error("timer 2 trigger does not follow pin");
endmodule

// ===== icr_far_end.sv
// Far-end model: capture pins, free-running counter, counter events.
// Assumes the bench commands it through its tasks on clk_i.
`timescale 1ns/1ps
module icr_far_end (
  input wire logic clk_i, // Core clock
  output logic [2:0] pin_o, // Capture pins
  output logic [3:0] evt_o, // Overflow, underflow, wrap, direction
  output logic [15:0] cnt_o, // Running count
  output logic t3_o // Timer 3 overflow
);
  logic [4:0] ev = 5'h00;
  initial pin_o = 3'h0;
  initial cnt_o = 16'h0000;
  assign evt_o = ev[3:0];
  assign t3_o = ev[4];
  always @(posedge clk_i) cnt_o <= cnt_o + 16'h0001;
  task automatic set_pin(input int c, input logic v);
    @(posedge clk_i);
    pin_o[c] <= v;
  endtask
  // Toggle one event line; n cycles later toggle back unless n is 0
  task automatic pulse(input int k, input int n);
    @(posedge clk_i);
    ev[k] <= ~ev[k];
    if (n > 0) begin
      repeat (n) @(posedge clk_i);
      ev[k] <= ~ev[k];
    end
  endtask
endmodule

// ===== tb_icr_top.sv
// Bench for the capture edge, filter, reload and flag control block.
// Assumes the far-end model for pins and counter events.
`timescale 1ns/1ps
module tb_icr_top;
  import icr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o, q;
  logic ack, rld, t3, trig, s;
  logic rld_seen = 1'b0;
  logic [47:0] cap;
  logic [2:0] pin, flg;
  logic [3:0] ev;
  logic [15:0] cnt;
  int fail_count = 0;
  int n_checks = 0;

  icr_far_end icr_far_end_inst (.clk_i(clk_i), .pin_o(pin), .evt_o(ev),
    .cnt_o(cnt), .t3_o(t3));
  icr_top icr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cap_pin_i(pin),
    .t3_overflow_i(t3), .cnt_evt_i(ev), .count_i(cnt), .cap_value_o(cap),
    .reload_o(rld), .event_flag_o(flg), .timer2_external_trigger_o(trig));

  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (rld === 1'b1) rld_seen <= 1'b1;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask

  // Poll a flag; on first sight the capture holds the count of that edge
  task automatic wait_flag(input int b, input logic cc, output logic seen);
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk_i);
      #1;
      if (!seen && flg[b] === 1'b1) begin
        seen = 1'b1;
        if (cc) chk("cap", cap[b*16+:16], 16'(cnt - 16'h1));
      end
    end
  endtask

  task automatic t_regs();
    rd("edge_rst", ICR_ADR_EDGE_RELOAD, 8'h00);
    rd("filt_rst", ICR_ADR_FILT_FLAG, 8'h00);
    rd("mode_rst", ICR_ADR_MODE, 8'h00);
    wb(10'h004, 1'b1, 8'hff);
    rd("unmapped", 10'h004, 8'h00);
    wb(ICR_ADR_EDGE_RELOAD, 1'b1, 8'ha5);
    rd("edge_rw", ICR_ADR_EDGE_RELOAD, 8'ha5);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h3f);
    rd("filt_rw", ICR_ADR_FILT_FLAG, 8'h38);
  endtask

  task automatic t_edges();
    logic ex;
    for (int ch = 0; ch < 3; ch++) begin
      for (int m = 0; m < 4; m++) begin
        wb(ICR_ADR_EDGE_RELOAD, 1'b1, 8'(m << (2 + 2*ch)) | 8'(ch + 1));
        wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
        for (int e = 0; e < 2; e++) begin
          ex = (m == 2) || (m == e);
          rld_seen = 1'b0;
          icr_far_end_inst.set_pin(ch, e == 0);
          wait_flag(ch, 1'b1, s);
          chk("edge_flag", s, ex);
          chk("cap_reload", rld_seen, ex);
          chk("t2_trig", trig, pin[2]);
          wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
          chk("flag_clr", flg, 3'h0);
        end
      end
    end
  endtask

  task automatic t_t3_filter();
    wb(ICR_ADR_EDGE_RELOAD, 1'b1, 8'h00);
    rld_seen = 1'b0;
    icr_far_end_inst.pulse(4, 1);
    repeat (3) @(posedge clk_i);
    #1;
    chk("t3_reload", rld_seen, 1'b1);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h08);
    icr_far_end_inst.set_pin(0, 1'b1);
    icr_far_end_inst.set_pin(0, 1'b0);
    wait_flag(0, 1'b0, s);
    chk("filt_glitch", s, 1'b0);
    icr_far_end_inst.set_pin(0, 1'b1);
    wait_flag(0, 1'b1, s);
    chk("filt_steady", s, 1'b1);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h0f);
    rd("write_one", ICR_ADR_FILT_FLAG, 8'h09);
    icr_far_end_inst.set_pin(0, 1'b0);
    repeat (12) @(posedge clk_i);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
    icr_far_end_inst.set_pin(0, 1'b1);
    icr_far_end_inst.set_pin(0, 1'b0);
    wait_flag(0, 1'b0, s);
    chk("nofilt_glitch", s, 1'b1);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
    for (int ch = 1; ch < 3; ch++) begin
      wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h30);
      icr_far_end_inst.set_pin(ch, 1'b1);
      icr_far_end_inst.set_pin(ch, 1'b0);
      wait_flag(ch, 1'b0, s);
      chk("filt_glitch_hi", s, 1'b0);
    end
  endtask

  task automatic t_quad();
    wb(ICR_ADR_MODE, 1'b1, 8'h01);
    icr_far_end_inst.pulse(0, 0);
    wait_flag(1, 1'b0, s);
    chk("dir_flag", s, 1'b1);
    repeat (20) @(posedge clk_i);
    #1;
    chk("dir_hold", flg[1], 1'b1);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
    chk("dir_clr", flg[1], 1'b0);
    // Clear write and direction change land on the same edge
    fork
      wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
      icr_far_end_inst.pulse(0, 0);
    join
    chk("set_wins", flg[1], 1'b1);
    wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
    chk("dir_reclr", flg[1], 1'b0);
    for (int k = 3; k > 0; k--) begin
      if (k == 1) wb(ICR_ADR_MODE, 1'b1, 8'h03);
      icr_far_end_inst.pulse(k, 1);
      wait_flag(0, 1'b0, s);
      chk("count_flag", s, 1'b1);
      wb(ICR_ADR_FILT_FLAG, 1'b1, 8'h00);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_edges();
    t_t3_filter();
    t_quad();
    tally_and_finish();
  end

  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule
